// File: hw/pfbp_top.sv
// Purpose: Save, restore, format and write-protect policy of a battery-backed disk.
// Assumes: Power, battery and spin inputs are asynchronous; operation done strobes are local.
// Notes: Registers are reached over AXI4-Lite.
//
// The AXI4-Lite slave port and the address map are this design's own decisions.

module pfbp_top #(
  parameter int SECOND_COUNT = pfbp_pkg::SECOND_CYCLES,
  parameter logic [13:0] SERIAL_INIT = pfbp_pkg::RST_SERIAL
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ac_fail_i,
  input wire logic battery_ready_i,
  input wire logic spin_down_req_i,
  input wire logic [1:0] saved_volume_i,
  input wire logic op_done_i,
  output logic restore_start_o,
  output logic init_start_o,
  output logic format_start_o,
  output logic save_start_o,
  output logic verify_start_o,
  output logic shutdown_o,
  output logic write_protect_o,
  output logic mark_invalid_o,
  output logic linked_cmds_o,
  output logic [2:0] target_id_o,
  output logic [13:0] drive_id_o
);
  import pfbp_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] ac_sync;
    logic [1:0] batt_sync;
    logic [1:0] spin_sync;
    logic spin_prev;
    logic [1:0] settle;
    pfbp_state_t state;
    logic [31:0] tick;
    logic [7:0] secs;
    logic [5:0] ctrl;
    logic [7:0] delay;
    logic [2:0] target;
    logic [13:0] serial;
    logic [23:0] gaps;
    logic [31:0] geom;
    logic [15:0] preamble;
    logic aw_held;
    logic w_held;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic restore_start;
    logic init_start;
    logic format_start;
    logic save_start;
    logic verify_start;
    logic shutdown;
    logic write_protect;
    logic mark_invalid;
    logic saved_ok;
  } pfbp_reg_t;

  pfbp_reg_t r;
  pfbp_reg_t next_r;
  logic ac;
  logic batt;
  logic spin_edge;
  logic wr_fire;
  logic wr_ok;
  logic [31:0] rd_word;

  assign ac = r.ac_sync[1];
  assign batt = r.batt_sync[1];
  assign spin_edge = r.spin_sync[1] & ~r.spin_prev;
  assign wr_fire = r.aw_held & r.w_held & ~r.bvalid;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    wr_ok = 1'b1;
    rd_word = 32'h00000000;
    unique case (s_axi_araddr)
      PFBP_CTRL: rd_word = {26'h0, r.ctrl};
      PFBP_DELAY: rd_word = {24'h000000, r.delay};
      PFBP_TARGET: rd_word = {29'h0, r.target};
      PFBP_SERIAL: rd_word = {18'h0, r.serial};
      PFBP_GAPS: rd_word = {8'h00, r.gaps};
      PFBP_GEOM: rd_word = r.geom;
      PFBP_PREAMBLE: rd_word = {16'h0000, r.preamble};
      PFBP_STATUS: rd_word = {24'h000000, r.saved_ok, r.mark_invalid,
                              r.write_protect, batt, r.state};
      PFBP_EVENT: rd_word = {24'h000000, r.secs};
      default: wr_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.ac_sync = {r.ac_sync[0], ac_fail_i};
    next_r.batt_sync = {r.batt_sync[0], battery_ready_i};
    next_r.spin_sync = {r.spin_sync[0], spin_down_req_i};
    next_r.spin_prev = r.spin_sync[1];
    next_r.settle = {r.settle[0], 1'b1};
    next_r.restore_start = 1'b0;
    next_r.init_start = 1'b0;
    next_r.format_start = 1'b0;
    next_r.save_start = 1'b0;
    next_r.verify_start = 1'b0;

    // AXI4-Lite write channel.
    if (s_axi_awvalid & r.awready) begin
      next_r.aw_held = 1'b1;
      next_r.awaddr = s_axi_awaddr;
      next_r.awready = 1'b0;
    end
    next_r.wready = ~r.w_held & ~(s_axi_wvalid & r.wready);
    if (s_axi_wvalid & r.wready) begin
      next_r.w_held = 1'b1;
      next_r.wdata = s_axi_wdata;
    end
    next_r.awready = ~r.aw_held & ~(s_axi_awvalid & r.awready);
    if (wr_fire) begin
      next_r.bvalid = 1'b1;
      next_r.bresp = 2'b00;
      unique case (r.awaddr)
        PFBP_CTRL: next_r.ctrl = r.wdata[5:0];
        PFBP_DELAY: begin
          if (r.wdata[7:0] != 8'h00) begin
            next_r.delay = r.wdata[7:0];
          end
        end
        PFBP_TARGET: next_r.target = r.wdata[2:0];
        PFBP_SERIAL: begin
          // An empty entry is bit 31 clear; out-of-range values are refused.
          if (r.wdata[31] && r.wdata[13:0] <= SERIAL_MAX) begin
            next_r.serial = r.wdata[13:0];
          end
        end
        PFBP_GAPS: next_r.gaps = r.wdata[23:0];
        PFBP_GEOM: next_r.geom = r.wdata;
        PFBP_PREAMBLE: next_r.preamble = r.wdata[15:0];
        PFBP_STATUS, PFBP_EVENT: next_r.bresp = 2'b00;
        default: next_r.bresp = 2'b10;
      endcase
    end
    if (r.bvalid & s_axi_bready) begin
      next_r.bvalid = 1'b0;
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
    end

    // AXI4-Lite read channel.
    next_r.arready = ~r.rvalid & ~(s_axi_arvalid & r.arready);
    if (s_axi_arvalid & r.arready) begin
      next_r.rvalid = 1'b1;
      next_r.rdata = rd_word;
      next_r.rresp = wr_ok ? 2'b00 : 2'b10;
    end
    if (r.rvalid & s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end

    // Write protection while the battery charges.
    // The battery level counts as unknown until its synchroniser has filled after reset.
    next_r.write_protect = r.ctrl[CTRL_LOW_BATTERY_WRITE_PROTECT] & ~(batt & r.settle[1]);
    if (~r.ctrl[CTRL_LOW_BATTERY_WRITE_PROTECT] & ~batt & r.settle[1]) begin
      next_r.mark_invalid = 1'b1;
    end

    // Policy sequencer.
    unique case (r.state)
      PFBP_BOOT: begin
        if (r.ctrl[CTRL_AUTO_RESTORE] && saved_volume_i == PFBP_VOL_VALID) begin
          next_r.restore_start = 1'b1;
          next_r.state = PFBP_RESTORE;
        end else begin
          next_r.init_start = 1'b1;
          next_r.state = PFBP_INIT;
        end
      end
      PFBP_RESTORE: begin
        if (op_done_i) begin
          next_r.state = PFBP_RUN;
        end
      end
      PFBP_INIT: begin
        if (op_done_i) begin
          next_r.format_start = 1'b1;
          next_r.state = PFBP_FORMAT;
        end
      end
      PFBP_FORMAT: begin
        if (op_done_i) begin
          next_r.state = PFBP_RUN;
        end
      end
      PFBP_RUN: begin
        next_r.tick = 32'h00000000;
        next_r.secs = 8'h00;
        if (ac) begin
          if (r.ctrl[CTRL_AUTO_SAVE] && batt) begin
            next_r.state = PFBP_WAIT;
          end else begin
            next_r.shutdown = 1'b1;
            next_r.state = PFBP_SHUTDOWN;
          end
        end else if (spin_edge && r.ctrl[CTRL_SPIN_SAVE]) begin
          next_r.save_start = 1'b1;
          next_r.state = PFBP_SAVE;
        end
      end
      PFBP_WAIT: begin
        if (!ac) begin
          next_r.state = PFBP_RUN;
        end else if (r.tick == 32'(SECOND_COUNT - 1)) begin
          next_r.tick = 32'h00000000;
          next_r.secs = r.secs + 8'h01;
          if (r.secs + 8'h01 == r.delay) begin
            next_r.save_start = 1'b1;
            next_r.state = PFBP_SAVE;
          end
        end else begin
          next_r.tick = r.tick + 32'h00000001;
        end
      end
      PFBP_SAVE: begin
        if (op_done_i) begin
          if (r.ctrl[CTRL_VERIFY]) begin
            next_r.verify_start = 1'b1;
            next_r.state = PFBP_VERIFY;
          end else begin
            next_r.saved_ok = 1'b1;
            next_r.shutdown = 1'b1;
            next_r.state = PFBP_SHUTDOWN;
          end
        end
      end
      PFBP_VERIFY: begin
        if (op_done_i) begin
          next_r.saved_ok = 1'b1;
          next_r.shutdown = 1'b1;
          next_r.state = PFBP_SHUTDOWN;
        end
      end
      PFBP_SHUTDOWN: begin
        next_r.shutdown = 1'b1;
      end
      default: next_r.state = PFBP_BOOT;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '0;
      r.state <= PFBP_BOOT;
      r.ctrl <= RST_CTRL;
      r.delay <= RST_DELAY;
      r.target <= RST_TARGET;
      r.serial <= SERIAL_INIT;
      r.gaps <= {RST_DATA_TO_NEXT_SECTOR_GAP, RST_HEADER_TO_DATA_GAP,
                 RST_INDEX_TO_HEADER_GAP};
      r.geom <= {RST_TABLE_COPIES, RST_REPLACEMENT_BLOCK, RST_TRACKS, RST_SECTORS};
      r.preamble <= {RST_HEADER_PREAMBLE, RST_DATA_PREAMBLE};
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bresp = r.bresp;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_arready = r.arready;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rvalid = r.rvalid;
  assign restore_start_o = r.restore_start;
  assign init_start_o = r.init_start;
  assign format_start_o = r.format_start;
  assign save_start_o = r.save_start;
  assign verify_start_o = r.verify_start;
  assign shutdown_o = r.shutdown;
  assign write_protect_o = r.write_protect;
  assign mark_invalid_o = r.mark_invalid;
  assign linked_cmds_o = r.ctrl[CTRL_LINKED];
  assign target_id_o = r.target;
  assign drive_id_o = r.serial;

endmodule : pfbp_top

// File: hw/pfbp_pkg.sv
// Purpose: Constants and types for the power-fail backup policy block.
// Assumes: 32-bit AXI4-Lite register access, 25 MHz clock.
// Notes: Offsets are byte addresses of aligned words.
package pfbp_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PFBP_CTRL = 8'h00;
  localparam logic [7:0] PFBP_DELAY = 8'h04;
  localparam logic [7:0] PFBP_TARGET = 8'h08;
  localparam logic [7:0] PFBP_SERIAL = 8'h0C;
  localparam logic [7:0] PFBP_GAPS = 8'h10;
  localparam logic [7:0] PFBP_GEOM = 8'h14;
  localparam logic [7:0] PFBP_PREAMBLE = 8'h18;
  localparam logic [7:0] PFBP_STATUS = 8'h1C;
  localparam logic [7:0] PFBP_EVENT = 8'h20;

  // ----------------------------------------------------------------
  // Control bit positions
  // ----------------------------------------------------------------
  localparam int CTRL_AUTO_SAVE = 0;
  localparam int CTRL_AUTO_RESTORE = 1;
  localparam int CTRL_VERIFY = 2;
  localparam int CTRL_LINKED = 3;
  localparam int CTRL_LOW_BATTERY_WRITE_PROTECT = 4;
  localparam int CTRL_SPIN_SAVE = 5;

  // ----------------------------------------------------------------
  // Values after reset and other constants
  // ----------------------------------------------------------------
  localparam logic [5:0] RST_CTRL = 6'h23;
  localparam logic [7:0] RST_DELAY = 8'h05;
  localparam logic [2:0] RST_TARGET = 3'h1;
  localparam logic [13:0] RST_SERIAL = 14'h0000;
  localparam logic [7:0] RST_INDEX_TO_HEADER_GAP = 8'h11;
  localparam logic [7:0] RST_HEADER_TO_DATA_GAP = 8'h11;
  localparam logic [7:0] RST_DATA_TO_NEXT_SECTOR_GAP = 8'h20;
  localparam logic [7:0] RST_SECTORS = 8'h04;
  localparam logic [7:0] RST_TRACKS = 8'h80;
  localparam logic [7:0] RST_REPLACEMENT_BLOCK = 8'h00;
  localparam logic [7:0] RST_TABLE_COPIES = 8'h01;
  localparam logic [7:0] RST_DATA_PREAMBLE = 8'h0F;
  localparam logic [7:0] RST_HEADER_PREAMBLE = 8'h0C;
  localparam logic [13:0] SERIAL_MAX = 14'h270F;
  localparam logic [4:0] BITS_PER_WORD_CLOCK = 5'h10;

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int SECOND_S = 1;
  localparam int SECOND_CYCLES = CLK_HZ * SECOND_S;

  typedef enum logic [1:0] {
    PFBP_VOL_NONE,
    PFBP_VOL_INVALID,
    PFBP_VOL_VALID
  } pfbp_vol_t;

  typedef enum logic [3:0] {
    PFBP_BOOT,
    PFBP_RESTORE,
    PFBP_INIT,
    PFBP_FORMAT,
    PFBP_RUN,
    PFBP_WAIT,
    PFBP_SAVE,
    PFBP_VERIFY,
    PFBP_SHUTDOWN
  } pfbp_state_t;

endpackage : pfbp_pkg

// File: tb/pfbp_properties.sv
// Purpose: Port-level properties of the backup policy block.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Bound onto every pfbp_top instance.
module pfbp_checker (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic s_axi_awready,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  input wire logic battery_ready_i,
  input wire logic restore_start_o,
  input wire logic init_start_o,
  input wire logic save_start_o,
  input wire logic verify_start_o,
  input wire logic shutdown_o,
  input wire logic write_protect_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  sequence s_boot_pulse;
    restore_start_o || init_start_o;
  endsequence
  sequence s_save_pulse;
    save_start_o ##1 !save_start_o;
  endsequence
  chk_boot_start: assert property ($rose(nrst_i) |-> ##[0:3] s_boot_pulse)
    else $error("no boot operation after reset");
  chk_boot_single: assert property (!(restore_start_o && init_start_o))
    else $error("restore and init together");
  chk_save_once: assert property (save_start_o |-> s_save_pulse)
    else $error("save start longer than one cycle");
  chk_verify_once: assert property (verify_start_o |=> !verify_start_o)
    else $error("verify start longer than one cycle");
  chk_down_sticky: assert property (shutdown_o |=> shutdown_o)
    else $error("shutdown dropped");
  chk_down_quiet: assert property (shutdown_o |-> !save_start_o && !verify_start_o)
    else $error("operation started after shutdown");
  chk_wp_release: assert property (battery_ready_i [*5] |-> !write_protect_o)
    else $error("write protect with battery ready");
  chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while response pending");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while response pending");
endmodule : pfbp_checker

bind pfbp_top pfbp_checker u_pfbp_checker (.clk_i, .nrst_i, .s_axi_awready, .s_axi_arready,
  .s_axi_bvalid, .s_axi_rvalid, .battery_ready_i, .restore_start_o, .init_start_o,
  .save_start_o, .verify_start_o, .shutdown_o, .write_protect_o);

// File: tb/pfbp_disk_model.sv
// Purpose: Backup disk and memory engine answering each started operation.
// Assumes: Every start is a one-cycle pulse.
// Notes: Answers after 3 cycles, or 12 when slow.
module pfbp_disk_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic go_i,
  input wire logic slow_i,
  output logic op_done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int wait_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_q <= 0;
      op_done_o <= 1'h0;
    end else begin
      op_done_o <= (wait_q == 1);
      if (go_i) begin
        wait_q <= slow_i ? 12 : 3;
      end else if (wait_q != 0) begin
        wait_q <= wait_q - 1;
      end
    end
  end
endmodule : pfbp_disk_model

// File: tb/tb_power_fail_backup_policy.sv
// Purpose: Self-checking bench of the backup policy block.
// Assumes: Ten cycles per second of delay.
// Notes: Each scenario resets the block, since shutdown is sticky.
module tb_power_fail_backup_policy;
  timeunit 1ns;
  timeprecision 1ns;
  import pfbp_pkg::*;
  logic clk_i = 1'h0, nrst_i = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, slow = 1'h0;
  logic ac_fail_i = 1'h0, battery_ready_i = 1'h1, spin_down_req_i = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] saved_volume_i = 2'h2, s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, op_done_i;
  logic restore_start_o, init_start_o, format_start_o, save_start_o, verify_start_o;
  logic shutdown_o, write_protect_o, mark_invalid_o, linked_cmds_o;
  logic [2:0] target_id_o;
  logic [13:0] drive_id_o;
  logic [1:0] last_bresp = 2'h0;
  int err_count = 0, samples_checked = 0, cnt[5];
  wire logic [4:0] pulses = {verify_start_o, save_start_o, format_start_o, init_start_o,
    restore_start_o};

  pfbp_top #(.SECOND_COUNT(10)) u_pfbp_top (.clk_i, .nrst_i, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ac_fail_i, .battery_ready_i, .spin_down_req_i,
    .saved_volume_i, .op_done_i, .restore_start_o, .init_start_o, .format_start_o,
    .save_start_o, .verify_start_o, .shutdown_o, .write_protect_o, .mark_invalid_o,
    .linked_cmds_o, .target_id_o, .drive_id_o);
  pfbp_disk_model u_pfbp_disk_model (.clk_i, .nrst_i, .go_i(|pulses), .slow_i(slow),
    .op_done_o(op_done_i));

  // ------------------------------------------------------------
  // Clock, pulse counters and shared tasks
  // ------------------------------------------------------------
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    foreach (cnt[k]) cnt[k] <= nrst_i ? cnt[k] + int'(pulses[k]) : 0;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    last_bresp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    cyc(2);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    cyc(1);
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check($sformatf("reg %h", a), d, e);
  endtask : rchk
  task automatic rst(input logic [1:0] v, input logic b);
    nrst_i <= 1'h0;
    saved_volume_i <= v;
    battery_ready_i <= b;
    ac_fail_i <= 1'h0;
    spin_down_req_i <= 1'h0;
    cyc(12);
    nrst_i <= 1'h1;
    cyc(60);
  endtask : rst
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] a[7] = '{PFBP_CTRL, PFBP_DELAY, PFBP_TARGET, PFBP_SERIAL, PFBP_GAPS,
      PFBP_GEOM, PFBP_PREAMBLE};
    logic [31:0] e[7] = '{32'h23, 32'h5, 32'h1, 32'h0, 32'h00201111, 32'h01008004, 32'hC0F};
    logic [31:0] d;
    logic [1:0] r;
    rst(2'h2, 1'h1);
    foreach (a[i]) rchk(a[i], e[i]);
    rd(8'h24, d, r);
    check("unmapped", r, 2'h2);
    check("target", target_id_o, 3'h1);
    check("invalid", mark_invalid_o, 1'h0);
    wr(8'h24, 32'h0);
    check("wr unmapped", last_bresp, 2'h2);
    wr(PFBP_DELAY, 32'h0);
    rchk(PFBP_DELAY, 32'h5);
    wr(PFBP_DELAY, 32'hFF);
    rchk(PFBP_DELAY, 32'hFF);
    wr(PFBP_TARGET, 32'h6);
    check("bresp", last_bresp, 2'h0);
    check("target", target_id_o, 3'h6);
    check("linked", linked_cmds_o, 1'h0);
    wr(PFBP_CTRL, 32'h2B);
    check("linked", linked_cmds_o, 1'h1);
    wr(PFBP_SERIAL, 32'h800004D2);
    check("serial", drive_id_o, 14'h04D2);
    wr(PFBP_SERIAL, 32'h00000011);
    check("serial", drive_id_o, 14'h04D2);
    wr(PFBP_SERIAL, 32'h8000270F);
    wr(PFBP_SERIAL, 32'h80002710);
    check("serial", drive_id_o, 14'h270F);
    $display("test regs done");
  endtask : t_regs
  task automatic t_boot();
    for (int v = 0; v < 3; v++) begin
      slow <= (v == 0);
      rst(v[1:0], 1'h1);
      check("restore", cnt[0], v == 2);
      check("init", cnt[1], v != 2);
      check("format", cnt[2], v != 2);
    end
    slow <= 1'h0;
    $display("test boot done");
  endtask : t_boot
  task automatic t_save(input logic v);
    int n = 0;
    rst(2'h2, 1'h1);
    wr(PFBP_CTRL, v ? 32'h27 : 32'h23);
    wr(PFBP_DELAY, 32'h2);
    ac_fail_i <= 1'h1;
    while (cnt[3] == 0 && n < 300) begin
      cyc(1);
      n++;
    end
    check("save delay", n >= 20 && n <= 32, 1'h1);
    cyc(60);
    check("verify", cnt[4], v);
    check("shutdown", shutdown_o, 1'h1);
    rchk(PFBP_STATUS, 32'h98);
    rchk(PFBP_EVENT, 32'h2);
    $display("test save done");
  endtask : t_save
  task automatic t_fail(input logic [31:0] ctrl, input int hold, input logic b);
    rst(2'h2, b);
    wr(PFBP_CTRL, ctrl);
    ac_fail_i <= 1'h1;
    cyc(hold);
    ac_fail_i <= 1'h0;
    cyc(120);
    check("save", cnt[3], 0);
    check("shutdown", shutdown_o, hold > 50);
    $display("test fail done");
  endtask : t_fail
  task automatic t_spin();
    rst(2'h2, 1'h1);
    for (int k = 0; k < 2; k++) begin
      wr(PFBP_CTRL, k ? 32'h23 : 32'h03);
      spin_down_req_i <= 1'h1;
      cyc(5);
      spin_down_req_i <= 1'h0;
      cyc(60);
      check("spin save", cnt[3], k);
    end
    $display("test spin done");
  endtask : t_spin
  task automatic t_wp();
    rst(2'h2, 1'h0);
    check("protect", write_protect_o, 1'h0);
    check("invalid", mark_invalid_o, 1'h1);
    wr(PFBP_CTRL, 32'h33);
    cyc(3);
    check("protect", write_protect_o, 1'h1);
    battery_ready_i <= 1'h1;
    cyc(6);
    check("protect", write_protect_o, 1'h0);
    $display("test protect done");
  endtask : t_wp

  initial begin
    cyc(20000);
    err_count++;
    wrap_up();
  end
  initial begin
    t_regs();
    t_boot();
    t_save(1'h0);
    t_save(1'h1);
    t_fail(32'h22, 100, 1'h1);
    t_fail(32'h23, 20, 1'h1);
    t_fail(32'h23, 100, 1'h0);
    t_spin();
    t_wp();
    wrap_up();
  end
endmodule : tb_power_fail_backup_policy
